/* logic/reset_power_manager_params.svh */
`ifndef RESET_POWER_MANAGER_PARAMS_SVH
`define RESET_POWER_MANAGER_PARAMS_SVH

// register indices; byte address is four times the index
`define RPM_IDX_VDC        12'hD0C
`define RPM_IDX_SRC4       12'hF0A
`define RPM_IDX_SRC        12'hF0B
`define RPM_IDX_SRC1       12'hF0C
`define RPM_IDX_SRC2       12'hF0D
`define RPM_IDX_SRC3       12'hF0E
`define RPM_IDX_WDM        12'hF0F
`define RPM_IDX_IRQ_REQ    12'hFFC
`define RPM_IDX_INT_MASK   12'hFFB

// reset values
`define RPM_RST_VDC        8'hF8
`define RPM_RST_SRC        8'h20
`define RPM_RST_CFG        8'h00
`define RPM_RST_WDM        8'h0D
`define RPM_RST_MASK       8'h00

// field positions
`define RPM_VDC_EN         0
`define RPM_VDC_LV         1
`define RPM_VDC_HV         2
`define RPM_VDC_ONES       8'hF8
`define RPM_SRC_PRE        0
`define RPM_SRC_DLY        5
`define RPM_SRC_STAT       7
`define RPM_WDM_HALT       2
`define RPM_WDM_STOP       3
`define RPM_IRQ_LV         5
`define RPM_OPT_DIV2       2

// timing
`define RPM_CLK_MHZ        25
`define RPM_T_POR_US       5000
`define RPM_T_WDT_BASE_MS  5
`define RPM_SHORT_CYCLES   18
`define RPM_WDM_WINDOW     120
`define RPM_RESTART_ADDR   16'h000C

`endif

/* logic/reset_power_manager_pkg.sv */
package reset_power_manager_pkg;
	// gray codes along brownout, por, short, run, halt, stop
	typedef enum logic [2:0] {
		ST_BROWN = 3'b000,
		ST_POR   = 3'b001,
		ST_SHORT = 3'b011,
		ST_RUN   = 3'b010,
		ST_HALT  = 3'b110,
		ST_STOP  = 3'b111
	} pm_state_t;
endpackage

/* logic/reset_power_manager.sv */
// Function
// - cpu runs on system clock; in halt interrupt logic runs on timer clock
// - option bit two selects oscillator rate or oscillator divided by two
// - control bit zero adds divide-by-16 after option divider, both clocks
// - prescaler enable cleared by power-on reset and stop recovery
// - below brownout point hold reset and stop crystal oscillator
// - below deep brownout point also switch off brownout comparator
// - supply back above brownout point gives full power-on reset
// - stop opcode turns off internal clock and oscillator
// - stop ends only by reset; restart at fixed address
// - stop recovery keeps marked bits and sets recovery status bit
// - halt gates cpu clock, oscillator and interrupt sources stay alive
// - halt exits on an enabled interrupt request, or to reset on watchdog timeout or brownout
// - voltage monitoring runs only while enable bit zero is set
// - high flag bit two above upper, low flag bit one below lower
// - low flag latches request bit five until software or reset clears
// - request is serviced only when mask enables it, else polled flag
// - bits seven to three read ones; two and one read only; zero rw
// - timer clears start long and 18-clock timers on rising transition
// - armed watchdog forces power-on reset when not refreshed in time
// - long timer runs on power-on, watchdog, stop recovery if delay set
// - recovery status reads zero after full reset, one after recovery
//
// The APB slave port was left to the implementer.
`timescale 1ns/100ps
`include "reset_power_manager_params.svh"

module reset_power_manager #(
	parameter int POR_CYCLES = `RPM_T_POR_US * `RPM_CLK_MHZ,
	parameter int WDT_BASE   = `RPM_T_WDT_BASE_MS * 1000 * `RPM_CLK_MHZ
) (
	input  wire logic        pclk,            // oscillator-rate clock
	input  wire logic        presetn,         // power-on reset, low
	input  wire logic        psel,            // apb select
	input  wire logic        penable,         // apb access phase
	input  wire logic        pwrite,          // apb direction
	input  wire logic [15:0] paddr,           // apb byte address
	input  wire logic [31:0] pwdata,          // apb write data
	output logic      [31:0] prdata,          // apb read data
	output logic             pready,          // apb ready
	output logic             pslverr,         // unmapped address
	input  wire logic [7:0]  user_option,     // option byte, static
	input  wire logic        halt_op,         // core executes halt
	input  wire logic        stop_op,         // core executes stop
	input  wire logic        wdt_refresh_op,  // core executes refresh
	input  wire logic        below_brownout,  // comparator, async
	input  wire logic        below_deep_bo,   // comparator, async
	input  wire logic        above_hv,        // comparator, async
	input  wire logic        below_lv,        // comparator, async
	input  wire logic        smr_event,       // recovery source, async
	input  wire logic [4:0]  irq_ext,         // other sources, async
	output logic             sys_reset_n,     // core reset, low
	output logic             cpu_clk_en,      // system clock tick
	output logic             tmr_clk_en,      // timer clock tick
	output logic             osc_enable,      // oscillator on
	output logic             bo_cmp_enable,   // brownout comparator on
	output logic             irq_lv,          // masked low-voltage request
	output logic [15:0]      restart_addr     // vector after reset
);
	import reset_power_manager_pkg::*;

	localparam int NSYNC = 10;

	logic [NSYNC-1:0] sync1_reg, sync2_reg;
	logic             bo_s, sub_s, hv_s, lv_s, smr_s;
	logic [4:0]       ext_s;
	pm_state_t        state_reg;
	logic [31:0]      cnt_reg;
	logic [7:0]       vdc_en_reg, src_reg, cfg1_reg, cfg2_reg, cfg3_reg, cfg4_reg;
	logic [7:0]       wdm_reg, mask_reg;
	logic             lvr_reg, opt_div2_reg, strap_done_reg;
	logic             wdt_armed_reg;
	logic [31:0]      wdt_cnt_reg, wdt_limit;
	logic [7:0]       wdm_win_reg;
	logic [4:0]       div_cnt_reg, div_term;
	logic             act_div2_reg, act_pre_reg, tick;
	logic             wdt_fire, wake, enter_full, enter_smr, keep_wdm;
	logic             lv_flag, hv_flag, wr_en, sel_ok;
	logic [11:0]      idx;
	logic [7:0]       rd_byte;
	logic             hit;

	// comparators and pins cross into pclk through two flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
		end else begin
			sync1_reg <= {irq_ext, smr_event, below_lv, above_hv, below_deep_bo,
				below_brownout};
			sync2_reg <= sync1_reg;
		end
	end
	assign bo_s  = sync2_reg[0];
	assign sub_s = sync2_reg[1];
	assign hv_s  = sync2_reg[2];
	assign lv_s  = sync2_reg[3];
	assign smr_s = sync2_reg[4];
	assign ext_s = sync2_reg[9:5];

	// event decode for the sequencer
	assign wake      = (lvr_reg & mask_reg[`RPM_IRQ_LV]) | (|(ext_s & mask_reg[4:0]));
	assign enter_smr = (state_reg == ST_STOP) && smr_s && !wdt_fire && !bo_s;
	assign enter_full = bo_s || (wdt_fire && state_reg != ST_POR && state_reg != ST_SHORT);
	assign keep_wdm  = wdt_fire && state_reg == ST_STOP;

	// power and reset sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= ST_POR;
		end else if (bo_s) begin
			state_reg <= ST_BROWN;
		end else begin
			unique case (state_reg)
				ST_BROWN: if (!sub_s) state_reg <= ST_POR;
				ST_POR:   if (cnt_reg == 32'(POR_CYCLES - 1)) state_reg <= ST_SHORT;
				ST_SHORT: if (cnt_reg == 32'(`RPM_SHORT_CYCLES - 1)) state_reg <= ST_RUN;
				ST_RUN: begin
					if (wdt_fire) state_reg <= ST_POR;
					else if (stop_op) state_reg <= ST_STOP;
					else if (halt_op) state_reg <= ST_HALT;
				end
				ST_HALT: begin
					if (wdt_fire) state_reg <= ST_POR;
					else if (wake) state_reg <= ST_RUN;
				end
				ST_STOP: begin
					if (wdt_fire) state_reg <= ST_POR;
					else if (smr_s) state_reg <= src_reg[`RPM_SRC_DLY] ? ST_POR : ST_SHORT;
				end
			endcase
		end
	end

	// timer restarts on every entry, acting as the timer clear edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_reg <= '0;
		end else if (enter_full || enter_smr || (state_reg == ST_RUN && wdt_fire)) begin
			cnt_reg <= '0;
		end else if (state_reg == ST_POR && cnt_reg == 32'(POR_CYCLES - 1)) begin
			cnt_reg <= '0;
		end else if (state_reg == ST_POR || state_reg == ST_SHORT) begin
			cnt_reg <= cnt_reg + 32'h1;
		end else begin
			cnt_reg <= '0;
		end
	end

	// power outputs follow the registered state, one cycle behind
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sys_reset_n   <= 1'b0;
			osc_enable    <= 1'b1;
			bo_cmp_enable <= 1'b1;
			restart_addr  <= `RPM_RESTART_ADDR;
		end else begin
			sys_reset_n   <= (state_reg == ST_RUN || state_reg == ST_HALT || state_reg == ST_STOP);
			osc_enable    <= !(state_reg == ST_BROWN || state_reg == ST_STOP);
			bo_cmp_enable <= !(state_reg == ST_BROWN && sub_s);
			restart_addr  <= `RPM_RESTART_ADDR;
		end
	end

	// option strap caught once after release; flash byte is static
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			opt_div2_reg   <= 1'b0;
			strap_done_reg <= 1'b0;
		end else if (!strap_done_reg) begin
			opt_div2_reg   <= user_option[`RPM_OPT_DIV2];
			strap_done_reg <= 1'b1;
		end
	end

	// clock divider; new selection only at wrap so no short pulse escapes
	always_comb begin
		unique case ({act_pre_reg, act_div2_reg})
			2'b00: div_term = 5'h00;
			2'b01: div_term = 5'h01;
			2'b10: div_term = 5'h0F;
			2'b11: div_term = 5'h1F;
		endcase
	end
	assign tick = (div_cnt_reg == div_term);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_cnt_reg  <= '0;
			act_div2_reg <= 1'b0;
			act_pre_reg  <= 1'b0;
		end else if (tick) begin
			div_cnt_reg  <= '0;
			act_div2_reg <= opt_div2_reg;
			act_pre_reg  <= src_reg[`RPM_SRC_PRE];
		end else begin
			div_cnt_reg  <= div_cnt_reg + 5'h01;
		end
	end

	// cpu gets ticks only in run; timer clock also in halt
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cpu_clk_en <= 1'b0;
			tmr_clk_en <= 1'b0;
		end else begin
			cpu_clk_en <= tick && state_reg == ST_RUN;
			tmr_clk_en <= tick && (state_reg == ST_RUN || state_reg == ST_HALT);
		end
	end

	// watchdog period: base times tap multiple
	always_comb begin
		unique case (wdm_reg[6:4])
			3'b001:  wdt_limit = 32'(WDT_BASE) << 6;
			3'b010:  wdt_limit = 32'(WDT_BASE) << 8;
			3'b100:  wdt_limit = 32'(WDT_BASE) << 10;
			default: wdt_limit = (wdm_reg[1:0] == 2'b11) ? (32'(WDT_BASE) << 4) :
				(32'(WDT_BASE) << wdm_reg[1:0]);
		endcase
	end
	assign wdt_fire = wdt_armed_reg && (wdt_cnt_reg == wdt_limit - 32'h1);

	// watchdog armed by first refresh, disarmed by any reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wdt_armed_reg <= 1'b0;
			wdt_cnt_reg   <= '0;
		end else if (enter_full || enter_smr || wdt_fire) begin
			wdt_armed_reg <= 1'b0;
			wdt_cnt_reg   <= '0;
		end else if (wdt_refresh_op && state_reg == ST_RUN) begin
			wdt_armed_reg <= 1'b1;
			wdt_cnt_reg   <= '0;
		end else if (wdt_armed_reg && (state_reg == ST_RUN
			|| (state_reg == ST_HALT && wdm_reg[`RPM_WDM_HALT])
			|| (state_reg == ST_STOP && wdm_reg[`RPM_WDM_STOP]))) begin
			wdt_cnt_reg   <= wdt_cnt_reg + 32'h1;
		end
	end

	// watchdog mode writable only for a short window after each reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wdm_win_reg <= '0;
		end else if (state_reg != ST_RUN && state_reg != ST_HALT && state_reg != ST_STOP) begin
			wdm_win_reg <= '0;
		end else if (wdm_win_reg != 8'(`RPM_WDM_WINDOW)) begin
			wdm_win_reg <= wdm_win_reg + 8'h01;
		end
	end

	// voltage flags exist only while monitoring is on
	assign lv_flag = vdc_en_reg[`RPM_VDC_EN] && lv_s;
	assign hv_flag = vdc_en_reg[`RPM_VDC_EN] && hv_s;

	// apb decode; write lands on the edge that samples pready
	assign idx    = paddr[13:2];
	assign sel_ok = paddr[15:14] == 2'b00 && paddr[1:0] == 2'b00;
	assign wr_en  = psel && penable && pready && pwrite && !pslverr;
	always_comb begin
		hit     = sel_ok;
		rd_byte = 8'h00;
		unique case (idx)
			`RPM_IDX_VDC:      rd_byte = `RPM_VDC_ONES | {5'h00, hv_flag, lv_flag,
				vdc_en_reg[`RPM_VDC_EN]};
			`RPM_IDX_SRC:      rd_byte = src_reg;
			`RPM_IDX_SRC1:     rd_byte = cfg1_reg;
			`RPM_IDX_SRC2:     rd_byte = cfg2_reg;
			`RPM_IDX_SRC3:     rd_byte = cfg3_reg;
			`RPM_IDX_SRC4:     rd_byte = cfg4_reg;
			`RPM_IDX_WDM:      rd_byte = 8'h00;
			`RPM_IDX_IRQ_REQ:  rd_byte = {2'b00, lvr_reg, ext_s};
			`RPM_IDX_INT_MASK: rd_byte = mask_reg;
			default:           hit     = 1'b0;
		endcase
	end

	// one wait state: data and ready registered in first access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= '0;
		end else if (psel && penable && !pready) begin
			pready  <= 1'b1;
			pslverr <= !hit;
			prdata  <= (hit && !pwrite) ? {24'h000000, rd_byte} : 32'h0000_0000;
		end else begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	// control registers; full reset restores all, recovery keeps most
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			vdc_en_reg <= `RPM_RST_VDC;
			src_reg    <= `RPM_RST_SRC;
			cfg1_reg   <= `RPM_RST_CFG;
			cfg2_reg   <= `RPM_RST_CFG;
			cfg3_reg   <= `RPM_RST_CFG;
			cfg4_reg   <= `RPM_RST_CFG;
			mask_reg   <= `RPM_RST_MASK;
		end else if (enter_full) begin
			vdc_en_reg <= `RPM_RST_VDC;
			src_reg    <= `RPM_RST_SRC;
			cfg1_reg   <= `RPM_RST_CFG;
			cfg2_reg   <= `RPM_RST_CFG;
			cfg3_reg   <= `RPM_RST_CFG;
			cfg4_reg   <= `RPM_RST_CFG;
			mask_reg   <= `RPM_RST_MASK;
		end else if (enter_smr) begin
			src_reg[`RPM_SRC_PRE]  <= 1'b0;
			src_reg[`RPM_SRC_STAT] <= 1'b1;
		end else if (wr_en) begin
			unique case (idx)
				`RPM_IDX_VDC:      vdc_en_reg[`RPM_VDC_EN] <= pwdata[`RPM_VDC_EN];
				`RPM_IDX_SRC:      src_reg[6:0] <= pwdata[6:0];
				`RPM_IDX_SRC1:     cfg1_reg <= pwdata[7:0];
				`RPM_IDX_SRC2:     cfg2_reg <= pwdata[7:0];
				`RPM_IDX_SRC3:     cfg3_reg <= pwdata[7:0];
				`RPM_IDX_SRC4:     cfg4_reg <= pwdata[7:0];
				`RPM_IDX_INT_MASK: mask_reg <= pwdata[7:0];
				default:           ;
			endcase
		end
	end

	// watchdog mode survives a timeout taken in stop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wdm_reg <= `RPM_RST_WDM;
		end else if (enter_full && !keep_wdm) begin
			wdm_reg <= `RPM_RST_WDM;
		end else if (wr_en && idx == `RPM_IDX_WDM && wdm_win_reg != 8'(`RPM_WDM_WINDOW)) begin
			wdm_reg <= pwdata[7:0];
		end
	end

	// latched low-voltage request; a new flag beats a software clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lvr_reg <= 1'b0;
			irq_lv  <= 1'b0;
		end else begin
			if (enter_full || enter_smr)
				lvr_reg <= 1'b0;
			else if (lv_flag)
				lvr_reg <= 1'b1;
			else if (wr_en && idx == `RPM_IDX_IRQ_REQ && pwdata[`RPM_IRQ_LV])
				lvr_reg <= 1'b0;
			irq_lv <= lvr_reg && mask_reg[`RPM_IRQ_LV];
		end
	end

	sequence s_stop_entry;
		state_reg == ST_RUN && !bo_s && !wdt_fire && stop_op;
	endsequence
	sequence s_stopped;
		state_reg == ST_STOP ##1 !osc_enable && !cpu_clk_en;
	endsequence

	property p_brown_hold;
		@(posedge pclk) disable iff (!presetn) bo_s |-> ##2 (!sys_reset_n && !osc_enable);
	endproperty
	a_brown_hold: assert property (p_brown_hold) else $error("brownout not holding reset");

	property p_deep_bo;
		@(posedge pclk) disable iff (!presetn)
			(state_reg == ST_BROWN && sub_s) |=> !bo_cmp_enable;
	endproperty
	a_deep_bo: assert property (p_deep_bo) else $error("comparator left on in deep brownout");

	property p_bo_recover;
		@(posedge pclk) disable iff (!presetn)
			(state_reg == ST_BROWN && !bo_s && !sub_s) |=> state_reg == ST_POR && cnt_reg == 0;
	endproperty
	a_bo_recover: assert property (p_bo_recover) else $error("no por after brownout");

	property p_stop;
		@(posedge pclk) disable iff (!presetn) s_stop_entry |=> s_stopped;
	endproperty
	a_stop: assert property (p_stop) else $error("stop did not stop clocks");

	property p_smr;
		@(posedge pclk) disable iff (!presetn)
			enter_smr |=> (!src_reg[`RPM_SRC_PRE] && src_reg[`RPM_SRC_STAT]);
	endproperty
	a_smr: assert property (p_smr) else $error("recovery status or prescaler wrong");

	property p_halt;
		@(posedge pclk) disable iff (!presetn)
			state_reg == ST_HALT |=> (!cpu_clk_en && osc_enable);
	endproperty
	a_halt: assert property (p_halt) else $error("halt clock gating wrong");

	property p_wake;
		@(posedge pclk) disable iff (!presetn)
			(state_reg == ST_HALT && wake && !wdt_fire && !bo_s) |=> state_reg == ST_RUN;
	endproperty
	a_wake: assert property (p_wake) else $error("halt not left on interrupt");

	property p_lv_latch;
		@(posedge pclk) disable iff (!presetn)
			(lv_flag && !enter_full && !enter_smr) |=> lvr_reg ##1
				irq_lv == $past(mask_reg[`RPM_IRQ_LV]); // mask may change under the request
	endproperty
	a_lv_latch: assert property (p_lv_latch) else $error("low-voltage request lost");

	property p_por_len;
		@(posedge pclk) disable iff (!presetn)
			(state_reg == ST_SHORT && $past(state_reg) == ST_POR) |-> $past(cnt_reg) ==
				32'(POR_CYCLES - 1);
	endproperty
	a_por_len: assert property (p_por_len) else $error("long timer ended early");
endmodule

/* tb/core_model.sv */
`timescale 1ns/100ps
module core_model (
	input  wire logic pclk,           // oscillator-rate clock
	input  wire logic sys_reset_n,    // core held in reset when low
	output logic      halt_op,        // halt executed
	output logic      stop_op,        // stop executed
	output logic      wdt_refresh_op  // refresh executed
);
	// quiet core at power-up
	initial begin
		halt_op = 1'b0;
		stop_op = 1'b0;
		wdt_refresh_op = 1'b0;
	end

	// op: 0 refresh, 1 halt, 2 stop; caller sits just after a rising edge
	task automatic exec(input int op);
		// sleep opcodes always follow a flush slot, never mid-instruction
		@(posedge pclk);
		// a core in reset issues nothing; port mode is never touched here
		if (sys_reset_n === 1'b1) begin
			wdt_refresh_op <= (op == 0);
			halt_op <= (op == 1);
			stop_op <= (op == 2);
		end
		@(posedge pclk);
		wdt_refresh_op <= 1'b0;
		halt_op <= 1'b0;
		stop_op <= 1'b0;
	endtask
endmodule

/* tb/tb_reset_power_manager.sv */
`timescale 1ns/100ps
`include "reset_power_manager_params.svh"
`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin errors++; \
	$display("Error %s expected %h seen %h", nm, exp, got); end end

module tb_reset_power_manager;
	import reset_power_manager_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [15:0] paddr, restart_addr;
	logic [31:0] pwdata, prdata;
	logic [7:0]  user_option, rd;
	logic        halt_op, stop_op, wdt_refresh_op, err;
	logic        below_brownout, below_deep_bo, above_hv, below_lv, smr_event;
	logic [4:0]  irq_ext;
	logic        sys_reset_n, cpu_clk_en, tmr_clk_en, osc_enable, bo_cmp_enable, irq_lv;
	int          errors, total_checks, c, t, n;

	reset_power_manager #(.POR_CYCLES(40), .WDT_BASE(20)) i_dut (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.user_option(user_option), .halt_op(halt_op), .stop_op(stop_op),
		.wdt_refresh_op(wdt_refresh_op), .below_brownout(below_brownout),
		.below_deep_bo(below_deep_bo), .above_hv(above_hv), .below_lv(below_lv),
		.smr_event(smr_event), .irq_ext(irq_ext), .sys_reset_n(sys_reset_n),
		.cpu_clk_en(cpu_clk_en), .tmr_clk_en(tmr_clk_en), .osc_enable(osc_enable),
		.bo_cmp_enable(bo_cmp_enable), .irq_lv(irq_lv), .restart_addr(restart_addr));
	core_model i_core (.pclk(pclk), .sys_reset_n(sys_reset_n), .halt_op(halt_op),
		.stop_op(stop_op), .wdt_refresh_op(wdt_refresh_op));

	// single-phase external clock on the oscillator input
	always #20 pclk = ~pclk;

	// one apb transfer; byte address is four times the index
	task automatic apb(input logic wr, input logic [11:0] idx, input logic [7:0] wd);
		int k;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {2'b00, idx, 2'b00};
		pwdata <= {24'h0, wd};
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 50);
		if (k >= 50) errors++;
		rd = prdata[7:0];
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rchk(input string nm, input logic [11:0] idx, input logic [7:0] exp);
		apb(1'b0, idx, 8'h00);
		`CHK(nm, exp, rd)
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge pclk);
	endtask
	// tick counts of both internal clocks over k edges
	task automatic ticks(input int k);
		c = 0;
		t = 0;
		repeat (k) begin
			@(posedge pclk);
			if (cpu_clk_en === 1'b1) c++;
			if (tmr_clk_en === 1'b1) t++;
		end
	endtask
	// bounded wait until the core is out of reset and clocked
	task automatic wait_run(input string nm, input int k);
		for (n = 0; n < k && !(sys_reset_n === 1'b1 && cpu_clk_en === 1'b1); n++)
			@(posedge pclk);
		`CHK(nm, 1'b1, sys_reset_n & cpu_clk_en)
	endtask

	task automatic t_reset;
		rchk("vdc", `RPM_IDX_VDC, 8'hF8);
		rchk("src", `RPM_IDX_SRC, 8'h20);
		rchk("cfg1", `RPM_IDX_SRC1, 8'h00);
		rchk("mask", `RPM_IDX_INT_MASK, 8'h00);
		apb(1'b0, 12'h123, 8'h00);
		`CHK("unmapped", 1'b1, err)
		`CHK("restart", 16'h000C, restart_addr)
	endtask

	task automatic t_clock;
		ticks(64);
		`CHK("div1 cpu", 64, c)
		`CHK("div1 tmr", 64, t)
		apb(1'b1, `RPM_IDX_SRC, 8'h21);
		cyc(40);
		ticks(64);
		`CHK("div16 cpu", 4, c)
		`CHK("div16 tmr", 4, t)
		apb(1'b1, `RPM_IDX_SRC, 8'h20);
		cyc(40);
	endtask

	task automatic t_volt;
		apb(1'b1, `RPM_IDX_VDC, 8'h00);
		rchk("vdc ro", `RPM_IDX_VDC, 8'hF8);
		below_lv <= 1'b1;
		above_hv <= 1'b1;
		cyc(6);
		rchk("vdc off", `RPM_IDX_VDC, 8'hF8);
		rchk("req off", `RPM_IDX_IRQ_REQ, 8'h00);
		apb(1'b1, `RPM_IDX_VDC, 8'hF9);
		cyc(6);
		rchk("vdc on", `RPM_IDX_VDC, 8'hFF);
		rchk("req set", `RPM_IDX_IRQ_REQ, 8'h20);
		`CHK("irq masked", 1'b0, irq_lv)
		apb(1'b1, `RPM_IDX_INT_MASK, 8'h20);
		cyc(2);
		`CHK("irq on", 1'b1, irq_lv)
		below_lv <= 1'b0;
		above_hv <= 1'b0;
		cyc(6);
		rchk("vdc clear", `RPM_IDX_VDC, 8'hF9);
		rchk("req held", `RPM_IDX_IRQ_REQ, 8'h20);
		apb(1'b1, `RPM_IDX_IRQ_REQ, 8'h20);
		cyc(2);
		rchk("req clr", `RPM_IDX_IRQ_REQ, 8'h00);
		`CHK("irq off", 1'b0, irq_lv)
		apb(1'b1, `RPM_IDX_VDC, 8'hF8);
		apb(1'b1, `RPM_IDX_INT_MASK, 8'h00);
	endtask

	task automatic t_halt;
		apb(1'b1, `RPM_IDX_INT_MASK, 8'h01);
		i_core.exec(1);
		cyc(4);
		// a masked source must not end the halt
		irq_ext <= 5'h02;
		ticks(32);
		`CHK("halt cpu", 0, c)
		`CHK("halt tmr", 32, t)
		irq_ext <= 5'h03;
		wait_run("halt wake", 30);
		irq_ext <= 5'h00;
		apb(1'b1, `RPM_IDX_INT_MASK, 8'h00);
	endtask

	task automatic t_stop;
		apb(1'b1, `RPM_IDX_SRC1, 8'h5A);
		apb(1'b1, `RPM_IDX_SRC, 8'h01);
		cyc(40);
		i_core.exec(2);
		cyc(4);
		`CHK("osc off", 1'b0, osc_enable)
		ticks(30);
		`CHK("stop cpu", 0, c)
		`CHK("stop tmr", 0, t)
		smr_event <= 1'b1;
		// delay bit clear: the long timer is skipped
		wait_run("stop wake", 50);
		smr_event <= 1'b0;
		`CHK("osc on", 1'b1, osc_enable)
		`CHK("restart", 16'h000C, restart_addr)
		rchk("src rec", `RPM_IDX_SRC, 8'h80);
		rchk("cfg kept", `RPM_IDX_SRC1, 8'h5A);
	endtask

	task automatic t_wdt;
		i_core.exec(0);
		for (n = 0; n < 3000 && sys_reset_n !== 1'b0; n++)
			@(posedge pclk);
		`CHK("wdt reset", 1'b0, sys_reset_n)
		wait_run("wdt back", 300);
		// keep counting in stop, shortest taps; lands inside the write window
		apb(1'b1, `RPM_IDX_WDM, 8'h08);
		rchk("src wdt", `RPM_IDX_SRC, 8'h20);
		rchk("cfg wdt", `RPM_IDX_SRC1, 8'h00);
		// a watchdog still running in stop ends the stop by a full reset
		i_core.exec(0);
		i_core.exec(2);
		cyc(2);
		`CHK("wdt stop osc", 1'b0, osc_enable)
		for (n = 0; n < 300 && sys_reset_n !== 1'b0; n++)
			@(posedge pclk);
		`CHK("wdt stop end", 1'b0, sys_reset_n)
		wait_run("wdt stop back", 300);
		rchk("src wdt stop", `RPM_IDX_SRC, 8'h20);
	endtask

	task automatic t_brown;
		below_brownout <= 1'b1;
		cyc(6);
		`CHK("bo reset", 1'b0, sys_reset_n)
		`CHK("bo osc", 1'b0, osc_enable)
		below_deep_bo <= 1'b1;
		cyc(6);
		`CHK("deep cmp", 1'b0, bo_cmp_enable)
		below_brownout <= 1'b0;
		below_deep_bo <= 1'b0;
		wait_run("bo back", 300);
		rchk("src por", `RPM_IDX_SRC, 8'h20);
		// option byte is only caught after a reset, so pulse it
		user_option <= 8'h04;
		presetn <= 1'b0;
		cyc(3);
		presetn <= 1'b1;
		wait_run("por div2", 300);
		ticks(64);
		`CHK("div2 cpu", 32, c)
		apb(1'b1, `RPM_IDX_SRC, 8'h21);
		cyc(80);
		ticks(64);
		`CHK("div32 cpu", 2, c)
	endtask

	task automatic conclude;
		if (errors == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// hang guard, well beyond the expected run
	initial begin
		#1200000;
		errors++;
		conclude();
	end

	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		user_option = 8'h00;
		{below_brownout, below_deep_bo, above_hv, below_lv, smr_event} = '0;
		irq_ext = 5'h00;
		errors = 0;
		total_checks = 0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		wait_run("por", 200);
		t_reset();
		t_clock();
		t_volt();
		t_halt();
		t_stop();
		t_wdt();
		t_brown();
		conclude();
	end
endmodule
